// [design/fsr_restore.sv]
// Purpose: State-restore unit: fetch image, check, then commit state; vector state is skipped when the OS bit is clear
// Assumes: Memory handshake holds request until ack; APB master is well behaved
// Notes: Staging buffer lets the fault check finish before any state changes
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_restore
    import fsr_pkg::*;
#(
    parameter bit SKIP_VEC_NO_OS = 1'b1 // Skip vector state when OS bit clear
) (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SRST_I,
    // APB register port
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Memory holding the image
    output logic MEM_REQ_O,
    output logic [63:0] MEM_ADDR_O,
    input wire logic MEM_ACK_I,
    input wire logic [127:0] MEM_RDATA_I,
    // Vector exception events from execution
    input wire logic VEC_EXC_VALID_I,
    input wire logic [5:0] VEC_EXC_FLAGS_I,
    output logic VEC_FAULT_O,
    // Restored state readout
    input wire logic [4:0] STATE_SEL_I,
    output logic [127:0] STATE_DATA_O,
    output fsr_fpenv_s FPENV_O,
    output logic [31:0] VCSR_O,
    output logic FP_PEND_O,
    // Completion
    output logic BUSY_O,
    output logic GPF_O
);
    localparam int NROWS = `FSR_SW_AREA_BYTE / `FSR_ROW_BYTES;
    localparam int NSTACK = 8;

    // Unit sequencing states
    typedef enum logic [1:0] {
        S_IDLE,
        S_FETCH,
        S_CHECK,
        S_COMMIT
    } fsr_state_e;

    fsr_state_e state_r; // Current step
    fsr_req_s req; // Request from registers
    fsr_layout_e lay_r; // Layout latched at start
    logic skip_vec_r; // Vector state not loaded this run
    logic start; // Start pulse from APB
    logic row_vld; // A row arrives
    logic [4:0] row_idx; // Index of that row
    logic fetch_done; // Last needed row arrived
    logic [127:0] stage_r [NROWS]; // Staged image rows
    logic [79:0] stack_r [NSTACK]; // Stack / packed-integer registers
    logic [127:0] vec_r [`FSR_VEC_WIDE]; // Vector registers
    fsr_fpenv_s env_nxt; // Decoded environment
    logic [31:0] vcsr_img; // Vector word taken from image
    logic rsv_bad; // Reserved vector bits set
    logic misalign; // Base not on a row boundary
    logic done_pls; // Restore finished cleanly
    logic gpf_pls; // Restore ended in fault
    logic [4:0] nvec; // Vector registers this layout holds

    // Register slave
    fsr_apb_regs u_regs (
        .clk_i(MCLK_I),
        .srst_i(SRST_I),
        .psel_i(PSEL_I),
        .penable_i(PENABLE_I),
        .pwrite_i(PWRITE_I),
        .paddr_i(PADDR_I),
        .pwdata_i(PWDATA_I),
        .prdata_o(PRDATA_O),
        .pready_o(PREADY_O),
        .pslverr_o(PSLVERR_O),
        .busy_i(BUSY_O),
        .done_set_i(done_pls),
        .gpf_set_i(gpf_pls),
        .mis_set_i(start & misalign),
        .fpenv_i({FPENV_O.fp_status_word, FPENV_O.fp_control_word}),
        .vcsr_i(VCSR_O),
        .req_o(req),
        .start_o(start)
    );

    // Alignment check on the base; the far side should keep it aligned
    assign misalign = |req.base[`FSR_ALIGN_BITS-1:0];

    // Row fetcher; never asks for the software-use tail
    fsr_row_fetch #(
        .ROWS(NROWS)
    ) u_fetch (
        .clk_i(MCLK_I),
        .srst_i(SRST_I),
        .start_i(start & ~misalign),
        .base_i(req.base),
        .row_vld_o(row_vld),
        .row_idx_o(row_idx),
        .done_o(fetch_done),
        .mem_req_o(MEM_REQ_O),
        .mem_addr_o(MEM_ADDR_O),
        .mem_ack_i(MEM_ACK_I)
    );

    // Sequencer: a misaligned base faults at once without any fetch
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            state_r <= S_IDLE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (start && !misalign) begin
                        state_r <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (fetch_done) begin
                        state_r <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    // Fault ends the run with nothing committed
                    state_r <= rsv_bad ? S_IDLE : S_COMMIT;
                end
                S_COMMIT: state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    assign BUSY_O = (state_r != S_IDLE);
    assign gpf_pls = ((state_r == S_CHECK) && rsv_bad) || (start && misalign);
    assign done_pls = (state_r == S_COMMIT);

    // Layout and skip choice taken in fetch, once the start write has landed
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            lay_r <= FSR_LAY_LEGACY;
            skip_vec_r <= 1'b0;
        end else if (state_r == S_FETCH) begin
            if (!req.long_mode) begin
                lay_r <= FSR_LAY_LEGACY;
            end else if (req.wide) begin
                lay_r <= FSR_LAY_WIDE64;
            end else begin
                lay_r <= FSR_LAY_WIDE32;
            end
            skip_vec_r <= SKIP_VEC_NO_OS & ~req.os_sup;
        end
    end

    // Staging buffer; no array reset, it is written before it is read
    always_ff @(posedge MCLK_I) begin
        if (row_vld) begin
            stage_r[row_idx] <= MEM_RDATA_I;
        end
    end

    // Vector word sits at bytes 24..27 of the image in every layout
    assign vcsr_img = stage_r[1][95:64];
    // Bits 16 and up are reserved; any one there is a fault
    assign rsv_bad = |vcsr_img[31:`FSR_VCSR_RSV_LO];

    // Decode rows 0 and 1 per layout
    always_comb begin
        env_nxt.fp_control_word = stage_r[0][15:0];
        env_nxt.fp_status_word = stage_r[0][31:16];
        env_nxt.fp_abridged_tag_byte = stage_r[0][39:32];
        env_nxt.fp_last_opcode = stage_r[0][63:48];
        env_nxt.ip = {32'h0, stage_r[0][95:64]};
        env_nxt.cs = stage_r[0][111:96];
        env_nxt.dp = {32'h0, stage_r[1][31:0]};
        env_nxt.ds = stage_r[1][47:32];
        case (lay_r)
            FSR_LAY_LEGACY: ;
            FSR_LAY_WIDE32: begin
                // Wide-mode rows carry no operand selector
                env_nxt.ds = 16'h0;
            end
            FSR_LAY_WIDE64: begin
                // Full 64-bit pointers, no selectors
                env_nxt.ip = stage_r[0][127:64];
                env_nxt.cs = 16'h0;
                env_nxt.dp = stage_r[1][63:0];
                env_nxt.ds = 16'h0;
            end
            default: ;
        endcase
    end

    assign nvec = (lay_r == FSR_LAY_LEGACY) ? 5'(`FSR_VEC_LEGACY) : 5'(`FSR_VEC_WIDE);

    // Commit environment; pending stack exceptions only stay flagged, none is raised
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            FPENV_O <= '0;
            FPENV_O.fp_control_word <= `FSR_FCW_RESET;
        end else if (state_r == S_COMMIT) begin
            FPENV_O <= env_nxt;
        end
    end

    // Pending level follows the restored summary bit; no delivery pulse here
    assign FP_PEND_O = FPENV_O.fp_status_word[7];

    // Stack registers in rows 2..9, low 80 bits; upper bytes ignored
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            for (int i = 0; i < NSTACK; i++) begin
                stack_r[i] <= 80'h0;
            end
        end else if (state_r == S_COMMIT) begin
            for (int i = 0; i < NSTACK; i++) begin
                stack_r[i] <= stage_r[`FSR_ROW_STACK0 + i][79:0];
            end
        end
    end

    // Vector registers from row 10; legacy loads 8, wide loads 16
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            for (int i = 0; i < `FSR_VEC_WIDE; i++) begin
                vec_r[i] <= 128'h0;
            end
        end else if (state_r == S_COMMIT && !skip_vec_r) begin
            for (int i = 0; i < `FSR_VEC_WIDE; i++) begin
                if (5'(i) < nvec) begin
                    vec_r[i] <= stage_r[`FSR_ROW_VEC0 + i];
                end
            end
        end
    end

    // Vector word: loaded quietly; new events set flags, commit loads image
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            VCSR_O <= `FSR_VCSR_RESET;
        end else if (state_r == S_COMMIT && !skip_vec_r) begin
            // A set flag with its mask clear raises nothing on load
            VCSR_O <= vcsr_img | {26'h0, VEC_EXC_VALID_I ? VEC_EXC_FLAGS_I : 6'h0};
        end else if (VEC_EXC_VALID_I) begin
            VCSR_O[5:0] <= VCSR_O[5:0] | VEC_EXC_FLAGS_I;
        end
    end

    // Fault only on a fresh occurrence of an unmasked exception
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            VEC_FAULT_O <= 1'b0;
        end else begin
            VEC_FAULT_O <= VEC_EXC_VALID_I &
                |(VEC_EXC_FLAGS_I & ~VCSR_O[`FSR_VCSR_MASK_LO +: 6]);
        end
    end

    // Fault level held until the next start
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            GPF_O <= 1'b0;
        end else if (gpf_pls) begin
            GPF_O <= 1'b1;
        end else if (start) begin
            GPF_O <= 1'b0;
        end
    end

    // Readout: 0..7 stack, 8..23 vector, others zero
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            STATE_DATA_O <= 128'h0;
        end else if (STATE_SEL_I < 5'd8) begin
            STATE_DATA_O <= {48'h0, stack_r[STATE_SEL_I[2:0]]};
        end else if (STATE_SEL_I < 5'd24) begin
            STATE_DATA_O <= vec_r[4'(STATE_SEL_I - 5'd8)];
        end else begin
            STATE_DATA_O <= 128'h0;
        end
    end

endmodule : fsr_restore

// [design/fsr_map.svh]
// Purpose: Offsets, field positions, reset values and counts of the state-restore unit
// Assumes: Included by bare name; definitions only
// Notes: Image rows are 16 bytes, fetched one row per memory transfer
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// Register byte addresses on the APB slave
`define FSR_OFS_CTRL 12'h000
`define FSR_OFS_BASE_LO 12'h004
`define FSR_OFS_BASE_HI 12'h008
`define FSR_OFS_STATUS 12'h00c
`define FSR_OFS_FPENV 12'h010
`define FSR_OFS_VCSR 12'h014

// Control register fields
`define FSR_CTRL_START 0
`define FSR_CTRL_WIDE 1
`define FSR_CTRL_LONG 2
`define FSR_CTRL_OSSUP 3

// Status register fields
`define FSR_ST_BUSY 0
`define FSR_ST_DONE 1
`define FSR_ST_GPF 2
`define FSR_ST_MISALIGN 3

// Image geometry
`define FSR_IMG_BYTES 512
`define FSR_ROW_BYTES 16
`define FSR_ALIGN_BITS 4
`define FSR_SW_AREA_BYTE 464
`define FSR_ROW_STACK0 2
`define FSR_ROW_VEC0 10
`define FSR_VEC_LEGACY 8
`define FSR_VEC_WIDE 16

// Vector control/status word: reserved bits and mask position
`define FSR_VCSR_RSV_LO 16
`define FSR_VCSR_FLAG_LO 0
`define FSR_VCSR_MASK_LO 7
`define FSR_VCSR_RESET 32'h0000_1f80

// Stack control word reset value
`define FSR_FCW_RESET 16'h037f

`endif

// [design/fsr_pkg.sv]
// Purpose: Types shared by the state-restore unit
// Assumes: Constants live in fsr_map.svh
// Notes: Layout enum selects how rows 0 and 1 are decoded
package fsr_pkg;

    // Image layout chosen at start
    typedef enum logic [1:0] {
        FSR_LAY_LEGACY,
        FSR_LAY_WIDE32,
        FSR_LAY_WIDE64
    } fsr_layout_e;

    // Software request captured from the control and base registers
    typedef struct packed {
        logic [63:0] base;
        logic wide;
        logic long_mode;
        logic os_sup;
    } fsr_req_s;

    // Restored stack environment
    typedef struct packed {
        logic [15:0] fp_control_word;
        logic [15:0] fp_status_word;
        logic [7:0] fp_abridged_tag_byte;
        logic [15:0] fp_last_opcode;
        logic [63:0] ip;
        logic [15:0] cs;
        logic [63:0] dp;
        logic [15:0] ds;
    } fsr_fpenv_s;

endpackage : fsr_pkg

// [design/fsr_apb_regs.sv]
// Purpose: APB slave holding the request and status registers
// Assumes: Zero wait states; read data built in the setup cycle
// Notes: Status flags are write-one-to-clear, hardware set wins
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_apb_regs
    import fsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Core side
    input wire logic busy_i,
    input wire logic done_set_i,
    input wire logic gpf_set_i,
    input wire logic mis_set_i,
    input wire logic [31:0] fpenv_i,
    input wire logic [31:0] vcsr_i,
    output fsr_req_s req_o,
    output logic start_o
);
    logic setup; // Setup cycle of any transfer
    logic wr_acc; // Write taking effect
    logic hit; // Address is mapped
    logic [2:0] sticky_r; // Done, fault, misaligned
    logic [31:0] rd_nxt;

    assign setup = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign pready_o = 1'b1; // Never stalls
    assign hit = (paddr_i <= `FSR_OFS_VCSR) && (paddr_i[1:0] == 2'b00);
    assign pslverr_o = psel_i & penable_i & ~hit;

    // Start pulses only on a write while idle; control and base writes during a run are dropped
    assign start_o = wr_acc & (paddr_i == `FSR_OFS_CTRL) & pwdata_i[`FSR_CTRL_START] & ~busy_i;

    // Request fields frozen while busy so a run sees one consistent request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            req_o <= '0;
        end else if (wr_acc && !busy_i) begin
            case (paddr_i)
                `FSR_OFS_CTRL: begin
                    req_o.wide <= pwdata_i[`FSR_CTRL_WIDE];
                    req_o.long_mode <= pwdata_i[`FSR_CTRL_LONG];
                    req_o.os_sup <= pwdata_i[`FSR_CTRL_OSSUP];
                end
                `FSR_OFS_BASE_LO: req_o.base[31:0] <= pwdata_i;
                `FSR_OFS_BASE_HI: req_o.base[63:32] <= pwdata_i;
                default: ;
            endcase
        end
    end

    // Sticky flags: set from hardware beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sticky_r <= '0;
        end else begin
            sticky_r <= (sticky_r & ~((wr_acc && paddr_i == `FSR_OFS_STATUS) ?
                pwdata_i[3:1] : 3'h0)) | {mis_set_i, gpf_set_i, done_set_i};
        end
    end

    // Read mux, registered in the setup cycle
    always_comb begin
        rd_nxt = 32'h0;
        case (paddr_i)
            `FSR_OFS_CTRL: rd_nxt = {28'h0, req_o.os_sup, req_o.long_mode, req_o.wide, 1'b0};
            `FSR_OFS_BASE_LO: rd_nxt = req_o.base[31:0];
            `FSR_OFS_BASE_HI: rd_nxt = req_o.base[63:32];
            `FSR_OFS_STATUS: rd_nxt = {28'h0, sticky_r, busy_i};
            `FSR_OFS_FPENV: rd_nxt = fpenv_i;
            `FSR_OFS_VCSR: rd_nxt = vcsr_i;
            default: rd_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0;
        end else if (setup) begin
            prdata_o <= rd_nxt;
        end
    end

endmodule : fsr_apb_regs

// [design/fsr_row_fetch.sv]
// Purpose: Reads image rows from memory, one request per row
// Assumes: Memory answers with data and ack in the same cycle
// Notes: Only rows below the software area are ever requested
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_row_fetch #(
    parameter int ROWS = `FSR_SW_AREA_BYTE / `FSR_ROW_BYTES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic start_i,
    input wire logic [63:0] base_i,
    output logic row_vld_o,
    output logic [4:0] row_idx_o,
    output logic done_o,
    // Memory
    output logic mem_req_o,
    output logic [63:0] mem_addr_o,
    input wire logic mem_ack_i
);
    logic [4:0] idx_r; // Row being requested

    if (ROWS < 1 || ROWS > 32) begin : g_rows_chk
        $error("ROWS out of range");
    end

    assign mem_addr_o = base_i + {55'h0, idx_r, 4'h0};
    assign row_vld_o = mem_req_o & mem_ack_i;
    assign row_idx_o = idx_r;
    assign done_o = row_vld_o && (idx_r == 5'(ROWS - 1));

    // Request held until acked; stops after the last row before 464
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mem_req_o <= 1'b0;
            idx_r <= 5'h0;
        end else if (start_i) begin
            mem_req_o <= 1'b1;
            idx_r <= 5'h0;
        end else if (done_o) begin
            mem_req_o <= 1'b0;
        end else if (row_vld_o) begin
            idx_r <= idx_r + 5'h1;
        end
    end

endmodule : fsr_row_fetch

// [verification/fsr_restore_sva.sv]
// Purpose: Port checker for the state-restore unit
// Assumes: Bound to fsr_restore from the bench top file
// Notes: Memory handshake, fault and vector event relations
`timescale 1ns/1ps
module fsr_restore_sva
    import fsr_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SRST_I,
    // Register bus
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // Memory
    input wire logic MEM_REQ_O,
    input wire logic [63:0] MEM_ADDR_O,
    input wire logic MEM_ACK_I,
    // Events and state
    input wire logic VEC_EXC_VALID_I,
    input wire logic [5:0] VEC_EXC_FLAGS_I,
    input wire logic VEC_FAULT_O,
    input wire fsr_fpenv_s FPENV_O,
    input wire logic [31:0] VCSR_O,
    input wire logic FP_PEND_O,
    input wire logic BUSY_O,
    input wire logic GPF_O
);
    logic [5:0] unmask_r; // Unmasked flags of last event, old mask
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);

    // Mask seen at event time; a commit in that cycle must not matter
    always_ff @(posedge MCLK_I) begin
        if (SRST_I || !VEC_EXC_VALID_I) begin
            unmask_r <= 6'h00;
        end else begin
            unmask_r <= VEC_EXC_FLAGS_I & ~VCSR_O[12:7];
        end
    end

    pready_high_a: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
        else $error("ready low in access phase");
    slverr_phase_a: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
        else $error("error outside access phase");
    req_hold_a: assert property (MEM_REQ_O && !MEM_ACK_I |=>
        MEM_REQ_O && $stable(MEM_ADDR_O))
        else $error("row request dropped or moved before ack");
    row_align_a: assert property (MEM_REQ_O |-> MEM_ADDR_O[3:0] == 4'h0 && BUSY_O)
        else $error("row request unaligned or while idle");
    row_step_a: assert property (MEM_REQ_O && MEM_ACK_I ##1 MEM_REQ_O |->
        MEM_ADDR_O == $past(MEM_ADDR_O) + 64'h10)
        else $error("row address did not step by one row");
    gpf_nochg_a: assert property ($rose(GPF_O) |-> $stable(VCSR_O) && $stable(FPENV_O))
        else $error("state changed with protection fault");
    vcsr_rsv_a: assert property (VCSR_O[31:16] == 16'h0000)
        else $error("reserved vector status bits loaded");
    pend_keep_a: assert property ($changed(FP_PEND_O) |-> $fell(BUSY_O))
        else $error("pending level moved outside restore");
    vfault_cause_a: assert property (VEC_FAULT_O == (|unmask_r))
        else $error("vector fault without unmasked event");
endmodule : fsr_restore_sva

// [verification/fsr_mem_model.sv]
// Purpose: Memory holding the saved state image
// Assumes: One row per request, request held until ack
// Notes: Random answer delay; data bus scrambles whenever not acked
`timescale 1ns/1ps
module fsr_mem_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Row requests
    input wire logic mem_req_i,
    input wire logic [63:0] mem_addr_i,
    input wire logic [63:0] base_i,
    output logic mem_ack_o = 1'b0,
    output logic [127:0] mem_rdata_o = 128'h0
);
    logic [7:0] img [512]; // Image bytes, laid out as a save would
    int acks = 0; // Rows delivered
    int bad = 0; // Rows asked from the software area
    int wait_n = 0; // Cycles left before answering
    logic [63:0] off;
    logic [127:0] d;

    // Answer one row; stale data never lingers on the bus
    always @(posedge clk_i) begin
        off = mem_addr_i - base_i;
        if (srst_i || mem_ack_o || !mem_req_i) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
        end else if (wait_n != 0) begin
            wait_n--; // Slow answer
            mem_rdata_o <= ~mem_rdata_o;
        end else begin
            if (off >= 64'd464) bad++;
            for (int k = 0; k < 16; k++) d[8*k +: 8] = img[off[8:0] + k];
            mem_ack_o <= 1'b1;
            mem_rdata_o <= d;
            acks++;
            wait_n = $urandom_range(3, 0);
        end
    end
endmodule : fsr_mem_model

// [verification/fp_simd_state_restore_tb_top.sv]
// Purpose: Self-checking bench for the state-restore unit
// Assumes: Zero-wait APB slave; memory model answers rows
// Notes: Expected state is predicted from the image bytes
`timescale 1ns/1ps
`include "fsr_map.svh"
module fp_simd_state_restore_tb_top
    import fsr_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vval = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, vcsr, q, e_vcsr;
    logic pready, pslverr, mreq, mack, vflt, pend, busy, gpf, e;
    logic [63:0] maddr, b, mbase = 64'h0;
    logic [127:0] mrdata, sdata;
    logic [5:0] vflg = 6'h00;
    logic [4:0] ssel = 5'h00;
    fsr_fpenv_s fpenv, e_env;
    logic [127:0] e_st [8]; // Expected stack registers
    logic [127:0] e_vec [16]; // Expected vector registers
    logic [3:0] lay [3] = '{4'h9, 4'hd, 4'hf}; // Legacy, wide32, wide64
    int miscompares = 0;
    int cmp_count = 0;

    fsr_restore dut (.MCLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .MEM_REQ_O(mreq), .MEM_ADDR_O(maddr),
        .MEM_ACK_I(mack), .MEM_RDATA_I(mrdata), .VEC_EXC_VALID_I(vval),
        .VEC_EXC_FLAGS_I(vflg), .VEC_FAULT_O(vflt), .STATE_SEL_I(ssel),
        .STATE_DATA_O(sdata), .FPENV_O(fpenv), .VCSR_O(vcsr), .FP_PEND_O(pend),
        .BUSY_O(busy), .GPF_O(gpf));
    fsr_mem_model mem (.clk_i(clk), .srst_i(srst), .mem_req_i(mreq), .mem_addr_i(maddr),
        .base_i(mbase), .mem_ack_o(mack), .mem_rdata_o(mrdata));

    // Free-running clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [255:0] g, input logic [255:0] x);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("FAIL t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // One APB transfer; waits for ready, never assumes a latency
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [127:0] row(input int r);
        logic [127:0] v;
        for (int k = 0; k < 16; k++) v[8*k +: 8] = mem.img[16*r + k];
        return v;
    endfunction : row

    // Random image with a legal vector status word
    task automatic fill();
        for (int i = 0; i < 512; i++) mem.img[i] = 8'($urandom);
        mem.img[26] = 8'h00;
        mem.img[27] = 8'h00;
        b = {$urandom, $urandom} & ~64'hf;
    endtask : fill

    // Compare all restored state against the prediction
    task automatic cmp_all();
        chk(fpenv, e_env);
        chk(vcsr, e_vcsr);
        for (int s = 0; s < 24; s++) begin
            ssel <= s[4:0];
            @(posedge clk);
            @(posedge clk);
            chk(sdata, s < 8 ? e_st[s] : e_vec[s-8]);
        end
    endtask : cmp_all

    // Start a restore, wait for it, predict and compare
    task automatic run(input logic [63:0] a, input logic [3:0] ctl, input bit flt);
        logic [127:0] r0, r1;
        int n;
        mbase <= a & ~64'hf;
        apb(1'b1, `FSR_OFS_BASE_LO, a[31:0]);
        apb(1'b1, `FSR_OFS_BASE_HI, a[63:32]);
        mem.acks = 0;
        mem.bad = 0;
        apb(1'b1, `FSR_OFS_CTRL, {28'h0, ctl});
        repeat (2) @(posedge clk);
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) miscompares++;
        r0 = row(0);
        r1 = row(1);
        if (!flt) begin
            e_env.fp_control_word = r0[15:0];
            e_env.fp_status_word = r0[31:16];
            e_env.fp_abridged_tag_byte = r0[39:32];
            e_env.fp_last_opcode = r0[63:48];
            if (ctl[2] && ctl[1]) begin
                e_env.ip = r0[127:64];
                e_env.cs = 16'h0;
                e_env.dp = r1[63:0];
                e_env.ds = 16'h0;
            end else begin
                e_env.ip = {32'h0, r0[95:64]};
                e_env.cs = r0[111:96];
                e_env.dp = {32'h0, r1[31:0]};
                e_env.ds = ctl[2] ? 16'h0 : r1[47:32];
            end
            for (int i = 0; i < 8; i++) e_st[i] = row(2 + i) & {48'h0, {80{1'b1}}};
            if (ctl[3]) begin
                e_vcsr = r1[95:64];
                for (int i = 0; i < (ctl[2] ? 16 : 8); i++) e_vec[i] = row(10 + i);
            end
            chk(mem.acks, 29);
        end else begin
            chk(gpf, 1'b1);
        end
        chk(mem.bad, 0);
        cmp_all();
    endtask : run

    // One vector event, fault expected one cycle later or not at all
    task automatic vev(input logic [5:0] f, input logic x);
        @(posedge clk);
        vval <= 1'b1;
        vflg <= f;
        @(posedge clk);
        vval <= 1'b0;
        #1 chk(vflt, x);
    endtask : vev

    // Hang guard
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        test_done();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h9653));
        e_env = '0;
        e_env.fp_control_word = `FSR_FCW_RESET;
        e_vcsr = `FSR_VCSR_RESET;
        for (int i = 0; i < 16; i++) e_vec[i] = 128'h0;
        for (int i = 0; i < 8; i++) e_st[i] = 128'h0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, `FSR_OFS_VCSR, 32'h0);
        chk(q, `FSR_VCSR_RESET);
        apb(1'b0, `FSR_OFS_FPENV, 32'h0);
        chk(q, {16'h0, `FSR_FCW_RESET});
        apb(1'b0, 12'h040, 32'h0);
        chk({q, e}, {32'h0, 1'b1});
        cmp_all();
        $display("test reset values done");
        for (int l = 0; l < 3; l++) begin
            fill();
            run(b, lay[l], 1'b0);
        end
        $display("test layouts done");
        fill();
        run(b, 4'h5, 1'b0);
        $display("test vector skip done");
        fill();
        mem.img[26 + $urandom_range(1, 0)] = 8'h01 << $urandom_range(7, 0);
        run(b, 4'hd, 1'b1);
        fill();
        run(b | 64'h8, 4'h9, 1'b1);
        chk(mem.acks, 0);
        apb(1'b0, `FSR_OFS_STATUS, 32'h0);
        chk(q & 32'hd, 32'hc);
        apb(1'b1, `FSR_OFS_STATUS, 32'he);
        apb(1'b0, `FSR_OFS_STATUS, 32'h0);
        chk(q & 32'he, 32'h0);
        $display("test faults done");
        fill();
        mem.img[2][7] = 1'b1;
        {mem.img[27], mem.img[26], mem.img[25], mem.img[24]} = 32'h0000_1f01;
        run(b, 4'h9, 1'b0);
        chk({pend, vflt}, 2'b10);
        vev(6'h02, 1'b0);
        vev(6'h01, 1'b1);
        $display("test pending and events done");
        test_done();
    end
endmodule : fp_simd_state_restore_tb_top

bind fsr_restore fsr_restore_sva u_sva (
    .MCLK_I(MCLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .MEM_REQ_O(MEM_REQ_O),
    .MEM_ADDR_O(MEM_ADDR_O), .MEM_ACK_I(MEM_ACK_I), .VEC_EXC_VALID_I(VEC_EXC_VALID_I),
    .VEC_EXC_FLAGS_I(VEC_EXC_FLAGS_I), .VEC_FAULT_O(VEC_FAULT_O), .FPENV_O(FPENV_O),
    .VCSR_O(VCSR_O), .FP_PEND_O(FP_PEND_O), .BUSY_O(BUSY_O), .GPF_O(GPF_O));
